// >>> verilog/freq_prot.sv
// Purpose: Over/under frequency, rate-of-change, undervoltage block and load shedding decision logic
// Assumes: Measurement inputs valid whenever hw_strobe is high
// Notes: Settings and status over a plain strobe port, read data one cycle later
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module freq_prot #(
    parameter int TICK_CYCLES = freq_prot_pkg::TICK_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [freq_prot_pkg::ADDR_W-1:0] addr,
    input wire logic [freq_prot_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [freq_prot_pkg::DATA_W-1:0] rdata,
    input wire logic hw_strobe,
    input wire logic [freq_prot_pkg::FREQ_W-1:0] freq_in,
    input wire logic [freq_prot_pkg::VOLT_W-1:0] phase_a_voltage,
    input wire logic breaker_open_input,
    input wire logic [freq_prot_pkg::N_EL-1:0] block_in,
    output logic [freq_prot_pkg::N_EL-1:0] pickup,
    output logic [freq_prot_pkg::N_EL-1:0] trip,
    output logic uv_pickup,
    output logic [freq_prot_pkg::FREQ_W-1:0] freq_report
);
    import freq_prot_pkg::*;

    typedef struct packed {
        logic [VOLT_W-1:0] inhib_v;
        logic [4:0] act_hw;
        logic [3:0] reset_cyc;
        logic ls_en;
        logic ls_type;
        logic [VOLT_W-1:0] uv_set;
        logic [N_EL-1:0] en;
        logic [N_EL-1:0][FREQ_W-1:0] pick;
        logic [N_EL-1:0][TIME_W-1:0] delay;
        logic [N_EL-1:0][TIME_W-1:0] rtime;
        logic [N_SLOPE-1:0][RATE_W-1:0] rate_pick;
        logic [RATE_HIST-1:0][FREQ_W-1:0] hist;
        logic [2:0] hist_n;
        logic [N_EL-1:0][4:0] act_cnt;
        logic [N_SLOPE-1:0][4:0] rate_cnt;
        logic [N_EL-1:0][4:0] absent;
        logic [N_EL-1:0][TIME_W-1:0] tmr;
        logic [N_EL-1:0][TIME_W-1:0] rst_tmr;
        logic [N_EL-1:0][2:0] dis_cnt;
        logic [N_EL-1:0] clr;
        logic [N_EL-1:0] pu;
        logic [N_EL-1:0] tr;
        logic [N_EL-1:0] pu_out;
        logic [N_EL-1:0] tr_out;
        logic uv_pu;
        logic [4:0] uv_cnt;
        logic [FREQ_W-1:0] freq_rep;
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t s;
    state_t next_s;
    logic [1:0] rst_sync;
    logic rst_n;
    logic inhib;
    logic hist_ok;
    logic init_trip;
    logic [3:0] el;
    logic el_hit;
    logic [4:0] eff_act;
    logic [4:0] need_rate;
    logic signed [FREQ_W:0] dfc;
    logic signed [47:0] prod;
    logic signed [47:0] thr;
    logic signed [RATE_W:0] rp;
    logic fok;
    logic rok;
    logic meet;
    logic present;
    logic clr_c;
    logic deact;
    logic ls_kill;
    logic ls_member;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        // Below 2 V or at or under the inhibit level, or blocked by undervoltage
        inhib = (phase_a_voltage <= s.inhib_v) || (phase_a_voltage < VOLT_W'(V_MIN_MEAS))
                || s.uv_pu;
        hist_ok = (s.hist_n == 3'(RATE_HIST));
        dfc = $signed({1'b0, freq_in}) - $signed({1'b0, s.hist[RATE_HIST-1]});
        prod = 48'(dfc) * 48'($signed({1'b0, freq_in}));
        init_trip = s.ls_type ? s.tr[SLOPE0] : s.tr[UNDER0];
        eff_act = (s.act_hw < 5'(RATE_MIN_ACT)) ? 5'(RATE_MIN_ACT) : s.act_hw;
        need_rate = eff_act - 5'(RATE_ACT_SUB);
        el = addr[7:4] - EL_FIRST;
        el_hit = (addr[7:4] >= EL_FIRST) && (addr[7:4] <= EL_LAST);
        rp = '0;
        thr = '0;
        fok = 1'b0;
        rok = 1'b0;
        meet = 1'b0;
        present = 1'b0;
        clr_c = 1'b0;
        deact = 1'b0;
        ls_kill = 1'b0;
        ls_member = 1'b0;

        // Tick prescaler for all millisecond timers
        next_s.tick = 1'b0;
        if (s.tick_cnt == TICK_W'(TICK_CYCLES - 1))
        begin
            next_s.tick_cnt = '0;
            next_s.tick = 1'b1;
        end
        else
            next_s.tick_cnt = s.tick_cnt + 1'b1;

        // Reported frequency
        if (inhib)
            next_s.freq_rep = '0;
        else if (hw_strobe)
            next_s.freq_rep = freq_in;

        // History for the rate computation
        if (hw_strobe)
        begin
            next_s.hist = {s.hist[RATE_HIST-2:0], freq_in};
            if (!hist_ok)
                next_s.hist_n = s.hist_n + 1'b1;
        end

        // Undervoltage block element
        if (hw_strobe)
        begin
            if (phase_a_voltage <= s.uv_set)
            begin
                next_s.uv_pu = 1'b1;
                next_s.uv_cnt = '0;
            end
            else if (s.uv_pu)
            begin
                if (21'(phase_a_voltage) * 21'(UV_RST_DEN) >= 21'(s.uv_set) * 21'(UV_RST_NUM))
                begin
                    if (s.uv_cnt == 5'(UV_RESET_HW - 1))
                    begin
                        next_s.uv_pu = 1'b0;
                        next_s.uv_cnt = '0;
                    end
                    else
                        next_s.uv_cnt = s.uv_cnt + 1'b1;
                end
                else
                    next_s.uv_cnt = '0;
            end
        end

        // Elements
        for (int k = 0; k < N_EL; k++)
        begin
            // Level detection, with hysteresis for the over and under elements only
            if (k < UNDER0)
            begin
                fok = freq_in >= s.pick[k];
                clr_c = ({1'b0, freq_in} + (FREQ_W+1)'(HYST_MHZ)) < {1'b0, s.pick[k]};
                present = fok;
            end
            else if (k < SLOPE0)
            begin
                fok = freq_in <= s.pick[k];
                clr_c = {1'b0, freq_in} > ({1'b0, s.pick[k]} + (FREQ_W+1)'(HYST_MHZ));
                present = fok;
            end
            else
            begin
                fok = freq_in <= s.pick[k];
                rp = (RATE_W+1)'($signed(s.rate_pick[k-SLOPE0]));
                if (rp < 0)
                begin
                    thr = (48'(rp) - 48'(RATE_MARGIN)) * 48'(RATE_DIV);
                    rok = hist_ok && (prod < thr);
                end
                else
                begin
                    thr = (48'(rp) + 48'(RATE_MARGIN)) * 48'(RATE_DIV);
                    rok = hist_ok && (prod > thr);
                end
                present = fok && rok;
                clr_c = !present;
            end

            // Load shedding pairing
            ls_member = s.ls_en && (k == 0 || k == UNDER0 || k == SLOPE0);
            ls_kill = (k == 0) && s.ls_en && !(init_trip && breaker_open_input);
            deact = inhib || !s.en[k] || (breaker_open_input && !ls_member);

            if (ls_kill || (block_in[k] && !s.tr[k]) || (deact && !s.tr[k]))
            begin
                // Idle while inhibited, blocked or not yet armed
                next_s.pu[k] = 1'b0;
                next_s.tr[k] = 1'b0;
                next_s.act_cnt[k] = '0;
                next_s.absent[k] = '0;
                next_s.tmr[k] = '0;
                next_s.rst_tmr[k] = '0;
                next_s.dis_cnt[k] = '0;
                if (k >= SLOPE0)
                    next_s.rate_cnt[k-SLOPE0] = '0;
            end
            else if (deact)
            begin
                // Tripped and deactivated: hold the trip for the disabling time
                if (s.tick)
                    next_s.dis_cnt[k] = s.dis_cnt[k] + 1'b1;
                if (s.dis_cnt[k] >= 3'(DIS_TICKS))
                begin
                    next_s.pu[k] = 1'b0;
                    next_s.tr[k] = 1'b0;
                    next_s.act_cnt[k] = '0;
                    next_s.tmr[k] = '0;
                    next_s.dis_cnt[k] = '0;
                end
            end
            else
            begin
                next_s.dis_cnt[k] = '0;
                if (hw_strobe)
                begin
                    next_s.clr[k] = clr_c;
                    if (fok && s.act_cnt[k] < s.act_hw)
                        next_s.act_cnt[k] = s.act_cnt[k] + 1'b1;
                    else if (!fok)
                        next_s.act_cnt[k] = '0;
                    if (k < SLOPE0)
                        meet = fok && (next_s.act_cnt[k] >= s.act_hw);
                    else
                    begin
                        // Rate counted only once the frequency has qualified
                        if (next_s.act_cnt[k] >= s.act_hw && rok)
                        begin
                            if (s.rate_cnt[k-SLOPE0] < need_rate)
                                next_s.rate_cnt[k-SLOPE0] = s.rate_cnt[k-SLOPE0] + 1'b1;
                        end
                        else
                            next_s.rate_cnt[k-SLOPE0] = '0;
                        meet = (next_s.act_cnt[k] >= s.act_hw)
                               && (next_s.rate_cnt[k-SLOPE0] >= need_rate) && rok;
                    end
                    if (meet)
                    begin
                        next_s.pu[k] = 1'b1;
                        next_s.absent[k] = '0;
                    end
                    else if (s.pu[k] && !s.tr[k])
                    begin
                        if (present)
                            next_s.absent[k] = '0;
                        else if (s.absent[k] + 1'b1 >= {s.reset_cyc, 1'b0})
                        begin
                            next_s.pu[k] = 1'b0;
                            next_s.absent[k] = '0;
                            next_s.tmr[k] = '0;
                        end
                        else
                            next_s.absent[k] = s.absent[k] + 1'b1;
                    end
                end
                // Operate timer
                if (next_s.pu[k] && !s.tr[k])
                begin
                    if (s.tmr[k] >= s.delay[k])
                        next_s.tr[k] = 1'b1;
                    else if (s.tick)
                        next_s.tmr[k] = s.tmr[k] + 1'b1;
                end
                // Reset timer once tripped
                if (s.tr[k])
                begin
                    if (!s.clr[k])
                        next_s.rst_tmr[k] = '0;
                    else if (s.rst_tmr[k] >= s.rtime[k])
                    begin
                        next_s.pu[k] = 1'b0;
                        next_s.tr[k] = 1'b0;
                        next_s.tmr[k] = '0;
                        next_s.rst_tmr[k] = '0;
                        next_s.act_cnt[k] = '0;
                    end
                    else if (s.tick)
                        next_s.rst_tmr[k] = s.rst_tmr[k] + 1'b1;
                end
            end
            next_s.pu_out[k] = next_s.pu[k] && !block_in[k];
            next_s.tr_out[k] = next_s.tr[k] && !block_in[k];
        end

        // Register writes
        if (wr_en)
        begin
            if (addr == REG_COMMON)
            begin
                next_s.inhib_v = wdata[15:0];
                next_s.act_hw = wdata[20:16];
                next_s.reset_cyc = wdata[27:24];
                next_s.ls_en = wdata[28];
                next_s.ls_type = wdata[29];
            end
            else if (addr == REG_UV)
                next_s.uv_set = wdata[15:0];
            else if (el_hit)
            begin
                case (addr[3:2])
                    EL_PICK:
                    begin
                        next_s.en[el] = wdata[31];
                        next_s.pick[el] = wdata[FREQ_W-1:0];
                    end
                    EL_DELAY: next_s.delay[el] = wdata[TIME_W-1:0];
                    EL_RTIME: next_s.rtime[el] = wdata[TIME_W-1:0];
                    EL_RATE:
                    begin
                        if (el >= 4'(SLOPE0))
                            next_s.rate_pick[el - 4'(SLOPE0)] = wdata[RATE_W-1:0];
                    end
                    default: ;
                endcase
            end
        end

        // Register reads, answer in the next cycle only
        next_s.rdata = '0;
        if (rd_en)
        begin
            if (addr == REG_COMMON)
                next_s.rdata = {2'b00, s.ls_type, s.ls_en, s.reset_cyc, 3'b000, s.act_hw, s.inhib_v};
            else if (addr == REG_UV)
                next_s.rdata = {16'h0000, s.uv_set};
            else if (addr == REG_STATUS)
                next_s.rdata = {12'h000, inhib, s.uv_pu, s.tr_out, s.pu_out};
            else if (addr == REG_FREQ)
                next_s.rdata = {12'h000, s.freq_rep};
            else if (el_hit)
            begin
                case (addr[3:2])
                    EL_PICK: next_s.rdata = {s.en[el], 11'h000, s.pick[el]};
                    EL_DELAY: next_s.rdata = {17'h00000, s.delay[el]};
                    EL_RTIME: next_s.rdata = {17'h00000, s.rtime[el]};
                    EL_RATE:
                    begin
                        if (el >= 4'(SLOPE0))
                            next_s.rdata = 32'($signed(s.rate_pick[el - 4'(SLOPE0)]));
                    end
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.inhib_v <= RST_INHIB_V;
            s.act_hw <= RST_ACT_HW;
            s.reset_cyc <= RST_RESET_CYC;
            s.uv_set <= RST_UV_SET;
            s.pick <= {N_EL{RST_PICK}};
            s.delay <= {N_EL{RST_DELAY}};
            s.rtime <= {N_EL{RST_RTIME}};
            s.rate_pick <= {N_SLOPE{RST_RATE}};
        end
        else
            s <= next_s;
    end

    assign rdata = s.rdata;
    assign pickup = s.pu_out;
    assign trip = s.tr_out;
    assign uv_pickup = s.uv_pu;
    assign freq_report = s.freq_rep;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Mirrors the deactivation term of the first under element
    logic deact_under0;
    assign deact_under0 = inhib || !s.en[UNDER0] || (breaker_open_input && !s.ls_en);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_inhib_zero_freq: assert property (inhib |=> (freq_report == '0))
        else $error("reported frequency not zero while inhibited");
    a_trip_needs_pu: assert property ((s.tr & ~s.pu) == '0)
        else $error("trip without pickup");
    a_block_outputs: assert property (((pickup | trip) & $past(block_in)) == '0)
        else $error("blocked element shows an output");
    a_uv_pick_set: assert property ((hw_strobe && phase_a_voltage <= s.uv_set) |=> uv_pickup)
        else $error("undervoltage block did not pick up");
    a_uv_stable_rst: assert property ($fell(s.uv_pu) |-> ($past(s.uv_cnt) == 5'(UV_RESET_HW - 1)))
        else $error("undervoltage block released early");
    a_low_volt_idle: assert property ((phase_a_voltage < VOLT_W'(V_MIN_MEAS)) |=> ((s.pu & ~s.tr) == '0))
        else $error("element picked up below minimum voltage");
    a_slope_min_act: assert property ($rose(s.pu[SLOPE0]) |->
        ($past(s.rate_cnt[0]) + 1'b1 >= 5'(RATE_MIN_ACT - RATE_ACT_SUB)))
        else $error("slope picked up before minimum half-waves");
    a_ls_over_gate: assert property ((s.ls_en && !(init_trip && breaker_open_input)) |=> !s.pu[0])
        else $error("paired over element active without initiator and open breaker");
    a_dis_hold: assert property (($fell(s.tr[UNDER0]) && $past(deact_under0)) |->
        ($past(s.dis_cnt[UNDER0]) >= 3'(DIS_TICKS)))
        else $error("trip cleared before disabling time");
endmodule : freq_prot

// >>> verilog/freq_prot_pkg.sv
// Purpose: Constants, widths and register map for the frequency protection block
// Assumes: 100 MHz clock, frequency in mHz, voltage in 10 mV units, times in 10 ms ticks
// Notes: Element order is over 0..2, under 3..5, slope 6..8
package freq_prot_pkg;
    // ------------------------------------------------------------
    // Widths and element layout
    // ------------------------------------------------------------
    localparam int N_EL = 9;
    localparam int N_SLOPE = 3;
    localparam int FREQ_W = 20;
    localparam int VOLT_W = 16;
    localparam int TIME_W = 15;
    localparam int RATE_W = 20;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TICK_W = 20;
    localparam int UNDER0 = 3;
    localparam int SLOPE0 = 6;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int DIS_MS = 50;
    localparam int DIS_TICKS = DIS_MS / TICK_MS;
    localparam int UV_RESET_HW = 20;
    // ------------------------------------------------------------
    // Thresholds
    // ------------------------------------------------------------
    localparam int HYST_MHZ = 10;
    localparam int RATE_MARGIN = 50;
    localparam int RATE_DIV = 2500;
    localparam int RATE_HIST = 5;
    localparam int RATE_MIN_ACT = 10;
    localparam int RATE_ACT_SUB = 7;
    localparam int V_MIN_MEAS = 200;
    localparam int UV_RST_NUM = 21;
    localparam int UV_RST_DEN = 20;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_COMMON = 8'h00;
    localparam logic [7:0] REG_UV = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_FREQ = 8'h0C;
    localparam logic [3:0] EL_FIRST = 4'h1;
    localparam logic [3:0] EL_LAST = 4'h9;
    localparam logic [1:0] EL_PICK = 2'h0;
    localparam logic [1:0] EL_DELAY = 2'h1;
    localparam logic [1:0] EL_RTIME = 2'h2;
    localparam logic [1:0] EL_RATE = 2'h3;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_INHIB_V = 16'h00C8;
    localparam logic [4:0] RST_ACT_HW = 5'h06;
    localparam logic [3:0] RST_RESET_CYC = 4'h0;
    localparam logic [15:0] RST_UV_SET = 16'h0000;
    localparam logic [19:0] RST_PICK = 20'h11170;
    localparam logic [14:0] RST_DELAY = 15'h0000;
    localparam logic [14:0] RST_RTIME = 15'h00C8;
    localparam logic [19:0] RST_RATE = 20'h00000;
endpackage : freq_prot_pkg

// >>> verification/meas_front_end.sv
// Purpose: Measurement front end model feeding the protection block
// Assumes: One strobe per zero crossing
// Notes: Frequency is scrambled off-strobe so the block cannot rely on it
`timescale 1ns/1ps
module meas_front_end (
    input wire logic clock,
    output logic hw_strobe,
    output logic [freq_prot_pkg::FREQ_W-1:0] freq_in,
    output logic [freq_prot_pkg::VOLT_W-1:0] phase_a_voltage
);
    initial
    begin
        hw_strobe = 1'b0;
        freq_in = 20'h00000;
        phase_a_voltage = 16'h0000;
    end
    task automatic send(input int f, input int v);
        @(posedge clock);
        hw_strobe <= 1'b1;
        freq_in <= f[19:0];
        phase_a_voltage <= v[15:0];
        @(posedge clock);
        hw_strobe <= 1'b0;
        freq_in <= ~f[19:0];
        @(posedge clock);
    endtask : send
endmodule : meas_front_end

// >>> verification/freq_prot_tb.sv
// Purpose: Self-checking bench for the frequency protection block
// Assumes: Tick shortened to 10 clocks
// Notes: Breaker opened only in the load shedding scenario
`timescale 1ns/1ps
module freq_prot_tb;
    import freq_prot_pkg::*;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] addr = 8'h00;
    logic [DATA_W-1:0] wdata = 32'h00000000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic hw_strobe;
    logic [FREQ_W-1:0] freq_in;
    logic [VOLT_W-1:0] phase_a_voltage;
    logic [N_EL-1:0] block_in = 9'h000;
    logic breaker = 1'b0;
    logic [N_EL-1:0] pickup;
    logic [N_EL-1:0] trip;
    logic uv_pickup;
    logic [FREQ_W-1:0] freq_report;
    logic [31:0] rd_val;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 60;
    int f;
    int run;
    always #5 clock = ~clock;
    freq_prot #(.TICK_CYCLES(10)) uut (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .hw_strobe(hw_strobe), .freq_in(freq_in),
        .phase_a_voltage(phase_a_voltage), .breaker_open_input(breaker), .block_in(block_in),
        .pickup(pickup), .trip(trip), .uv_pickup(uv_pickup), .freq_report(freq_report));
    meas_front_end fe (.clock(clock), .hw_strobe(hw_strobe), .freq_in(freq_in), .phase_a_voltage(phase_a_voltage));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 rd_val = rdata;
    endtask : rd
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // Whole run is well under 3000 cycles
    initial
    begin
        #50000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(REG_COMMON);
        check(rd_val, 32'h000600C8);
        rd(8'hF0);
        check(rd_val, 32'h00000000);
        wr(8'h10, 32'h8000C350);
        wr(8'h40, 32'h8000AFC8);
        $display("registers done");
        run = 0;
        repeat (8)
        begin
            f = 50000 + ($unsigned($random(seed)) % 1000);
            fe.send(f, 1000);
            run++;
            #1;
            check(pickup[0], run >= 6);
            check(freq_report, f);
            check(pickup[3], 0);
        end
        check(trip[0], 1);
        @(posedge clock);
        block_in <= 9'h001;
        repeat (2) @(posedge clock);
        #1 check(pickup[0], 0);
        check(trip[0], 0);
        @(posedge clock);
        block_in <= 9'h000;
        repeat (2) @(posedge clock);
        #1 check(pickup[0], 1);
        check(trip[0], 1);
        $display("over and block done");
        for (run = 1; run <= 6; run++)
        begin
            f = 40000 + ($unsigned($random(seed)) % 5001);
            fe.send(f, 1000);
            #1 check(pickup[3], run >= 6);
        end
        rd(REG_STATUS);
        check(rd_val[3], 1);
        fe.send(45000, 150);
        #1 check(freq_report, 0);
        repeat (30) @(posedge clock);
        #1 check(trip[3], 1);
        repeat (40) @(posedge clock);
        #1 check(trip[3], 0);
        check(trip[0], 0);
        $display("under and inhibit done");
        wr(REG_UV, 32'h000001F4);
        fe.send(45000, 400);
        #1 check(uv_pickup, 1);
        for (run = 1; run <= 20; run++)
        begin
            fe.send(45000, 525);
            #1 check(uv_pickup, run < 20);
        end
        $display("undervoltage done");
        wr(REG_COMMON, 32'h100600C8);
        for (run = 1; run <= 6; run++)
        begin
            fe.send(44000, 1000);
            #1 check(pickup[3], run >= 6);
        end
        check(trip[3], 1);
        for (run = 1; run <= 12; run++)
        begin
            if (run == 7)
            begin
                @(posedge clock);
                breaker <= 1'b1;
            end
            fe.send(50500, 1000);
            #1 check(pickup[0], run >= 12);
        end
        check(trip[0], 1);
        $display("load shedding done");
        wrap_up();
    end
endmodule : freq_prot_tb
